/* File: bwc_pkg.sv */
// Purpose: Constants for the bridge window and control register tail
// Assumes: APB byte addresses, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package bwc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] OFS_PREF_TOP_HI = 8'h2c;
  localparam logic [7:0] OFS_IO_HI       = 8'h30;
  localparam logic [7:0] OFS_CAP_PTR     = 8'h34;
  localparam logic [7:0] OFS_INT_BRIDGE  = 8'h3c;

  localparam logic [31:0] PREF_TOP_HI_RST = 32'h0000_0000;
  localparam logic [15:0] IO_HALF_RST     = 16'h0000;
  localparam logic [7:0]  CAP_PTR_VAL     = 8'h40;
  localparam logic [7:0]  INT_LINE_RST    = 8'h00;
  localparam logic [7:0]  INT_PIN_RST     = 8'h00;
  localparam logic [15:0] BRIDGE_CTL_RST  = 16'h0000;

  // Bridge control bit positions, within the 16-bit field (dword bit minus 16)
  localparam int unsigned BC_POISON = 0;
  localparam int unsigned BC_ERRFWD = 1;
  localparam int unsigned BC_ISA    = 2;
  localparam int unsigned BC_VGA    = 3;
  localparam int unsigned BC_VGA16  = 4;
  localparam int unsigned BC_SBR    = 6;
  // Writable bits: 16..20 and 22; bits 21, 23..27 and 28..31 read zero
  localparam logic [15:0] BC_WR_MASK = 16'h005f;

  localparam logic [19:0] PREF_LOW_ONES = 20'hf_ffff;
  localparam logic [31:0] VGA_MEM_LO    = 32'h000a_0000;
  localparam logic [31:0] VGA_MEM_HI    = 32'h000b_ffff;
  localparam logic [9:0]  VGA_IO_A_LO   = 10'h3b0;
  localparam logic [9:0]  VGA_IO_A_HI   = 10'h3bb;
  localparam logic [9:0]  VGA_IO_B_LO   = 10'h3c0;
  localparam logic [9:0]  VGA_IO_B_HI   = 10'h3df;
  localparam logic [15:0] IO_FIRST_64K  = 16'h0000;
  localparam logic [1:0]  ISA_LOW_QTR   = 2'h0;
  localparam logic [5:0]  IO_ALIAS_ZERO = 6'h00;

  localparam logic [2:0]  ERR_NONE = 3'h0;
endpackage

/* File: bwc_fwd_decode.sv */
// Purpose: Combinational window and legacy-range decode for one request
// Assumes: Bounds already assembled by the caller
// Notes:   Results are registered in the register block
module bwc_fwd_decode
  import bwc_pkg::*;
(
  input  wire logic [63:0] reqAddr,
  input  wire logic        reqIsIo,
  input  wire logic [31:0] ioBottom,
  input  wire logic [31:0] ioTop,
  input  wire logic [63:0] prefBottom,
  input  wire logic [63:0] prefTop,
  input  wire logic        isaEn,
  input  wire logic        vgaEn,
  input  wire logic        vga16,
  output logic             ioInWindow,
  output logic             prefInWindow,
  output logic             isaUpstream,
  output logic             ioDownstream,
  output logic             vgaHit
);
  import bwc_pkg::*;

  function automatic logic inRange(input logic [63:0] a, input logic [63:0] lo,
                                   input logic [63:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  logic [31:0] ioAddr;
  logic        first64k;
  logic        vgaIoLow;
  logic        vgaIo;
  logic        vgaMem;

  assign ioAddr   = reqAddr[31:0];
  assign first64k = reqAddr[63:16] == {32'h0000_0000, IO_FIRST_64K};
  // Inclusive on both bounds
  assign ioInWindow   = reqIsIo && reqAddr[63:32] == 32'h0000_0000 &&
                        inRange({32'h0000_0000, ioAddr}, {32'h0000_0000, ioBottom},
                                {32'h0000_0000, ioTop}); // R04
  assign prefInWindow = !reqIsIo && inRange(reqAddr, prefBottom, prefTop); // R04
  // Top 768 bytes of each 1KB block in the first 64KB go upstream
  assign isaUpstream  = isaEn && ioInWindow && first64k &&
                        reqAddr[9:8] != ISA_LOW_QTR; // R09
  assign ioDownstream = ioInWindow && !isaUpstream; // R09
  assign vgaIoLow = inRange({54'h0, ioAddr[9:0]}, {54'h0, VGA_IO_A_LO}, {54'h0, VGA_IO_A_HI}) ||
                    inRange({54'h0, ioAddr[9:0]}, {54'h0, VGA_IO_B_LO}, {54'h0, VGA_IO_B_HI}); // R11
  assign vgaIo  = reqIsIo && first64k && vgaIoLow &&
                  (!vga16 || ioAddr[15:10] == IO_ALIAS_ZERO); // R12
  assign vgaMem = !reqIsIo && inRange(reqAddr, {32'h0000_0000, VGA_MEM_LO},
                                      {32'h0000_0000, VGA_MEM_HI}); // R10
  assign vgaHit = vgaEn && (vgaIo || vgaMem); // R10
endmodule

/* File: bwc_regs.sv */
// Purpose: Bridge window upper bounds, capability pointer, interrupt and control
// Assumes: APB slave, no wait states, sys_clk 100 MHz
// Notes:   Lower window bounds come from the neighbouring register block
//
// What this block does
// R01: RW prefetch window top bits 63:32, reset zero
// R02: RW I/O bottom bits 31:16, reset zero
// R03: RW I/O top bits 31:16, reset zero
// R04: Inclusive bounds decide window membership
// R05: Capability pointer reads constant 40h
// R06: Interrupt pin RO, reset 00h, loadable on downstream ports only
// R07: Poison response bit gates poison detection
// R08: Error forward bit gates secondary error messages
// R09: ISA bit sends top-768 ranges upstream
// R10: VGA bit enables legacy VGA memory/IO forwarding
// R11: VGA IO ranges 3B0-3BB, 3C0-3DF
// R12: Decode width bit selects 10 or 16
// R13: Secondary bus reset drives port resets
// R14: Legacy control bits read zero, ignore writes
// R15: Prefetch top low 20 bits all ones
module bwc_regs
  import bwc_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                portIsUpstream,
  input  wire logic                intPinLoad,
  input  wire logic [7:0]          intPinValue,
  input  wire logic [31:0]         ioBottomLow,
  input  wire logic [31:0]         ioTopLow,
  input  wire logic [63:0]         prefBottom,
  input  wire logic [11:0]         prefTopMid,
  input  wire logic                reqValid,
  input  wire logic                reqIsIo,
  input  wire logic [63:0]         reqAddr,
  output logic                     decValid,
  output logic                     ioInWindow,
  output logic                     prefInWindow,
  output logic                     isaUpstream,
  output logic                     ioDownstream,
  output logic                     vgaHit,
  input  wire logic                poisonIn,
  output logic                     poisonDetected,
  input  wire logic [2:0]          errMsgIn,
  output logic      [2:0]          errMsgOut,
  output logic                     portRstOut,
  output logic                     allDownRstOut
);
  import bwc_pkg::*;

  logic [31:0] prefTopHigh_q;
  logic [15:0] ioBottomHigh_q;
  logic [15:0] ioTopHigh_q;
  logic [7:0]  intLine_q;
  logic [7:0]  intPin_q;
  logic [15:0] bridgeCtl_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic        pready_q;
  logic        pslverr_q;
  logic        mapped;
  logic        setupPhase;
  logic        wrAccept;
  logic [31:0] ioBottom;
  logic [31:0] ioTop;
  logic [63:0] prefTop;
  logic        decIoWin;
  logic        decPrefWin;
  logic        decIsa;
  logic        decIoDown;
  logic        decVga;
  logic        decValid_q;
  logic        ioWin_q;
  logic        prefWin_q;
  logic        isaUp_q;
  logic        ioDown_q;
  logic        vga_q;
  logic        poison_q;
  logic [2:0]  errOut_q;
  logic        portRst_q;
  logic        allDownRst_q;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = a == OFS_PREF_TOP_HI || a == OFS_IO_HI ||
               a == OFS_CAP_PTR || a == OFS_INT_BRIDGE;
  endfunction

  assign setupPhase = psel && !penable;
  assign wrAccept   = psel && penable && pready_q && pwrite && isMapped(paddr);
  assign mapped     = isMapped(paddr);

  // Read data is assembled in the setup cycle and held for the access cycle
  always_comb begin
    prdata_d = '0;
    unique case (paddr)
      OFS_PREF_TOP_HI: prdata_d = prefTopHigh_q; // R01
      OFS_IO_HI:       prdata_d = {ioTopHigh_q, ioBottomHigh_q}; // R02 R03
      OFS_CAP_PTR:     prdata_d = {24'h00_0000, CAP_PTR_VAL}; // R05
      OFS_INT_BRIDGE:  prdata_d = {bridgeCtl_q & BC_WR_MASK, intPin_q, intLine_q}; // R14
      default:         prdata_d = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setupPhase;
      pslverr_q <= setupPhase && !mapped;
      if (setupPhase) begin
        prdata_q <= pwrite ? '0 : prdata_d;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prefTopHigh_q  <= PREF_TOP_HI_RST;
      ioBottomHigh_q <= IO_HALF_RST;
      ioTopHigh_q    <= IO_HALF_RST;
      intLine_q      <= INT_LINE_RST;
      bridgeCtl_q    <= BRIDGE_CTL_RST;
    end else if (wrAccept) begin
      unique case (paddr)
        OFS_PREF_TOP_HI: prefTopHigh_q <= pwdata; // R01
        OFS_IO_HI: begin
          ioBottomHigh_q <= pwdata[15:0]; // R02
          ioTopHigh_q    <= pwdata[31:16]; // R03
        end
        OFS_INT_BRIDGE: begin
          intLine_q   <= pwdata[7:0];
          bridgeCtl_q <= pwdata[31:16] & BC_WR_MASK; // R14
        end
        default: begin
        end
      endcase
    end
  end

  // Pin value is only overridable on downstream ports
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      intPin_q <= INT_PIN_RST; // R06
    end else if (intPinLoad && !portIsUpstream) begin
      intPin_q <= intPinValue; // R06
    end
  end

  assign ioBottom = {ioBottomHigh_q, ioBottomLow[15:0]};
  assign ioTop    = {ioTopHigh_q, ioTopLow[15:0]};
  assign prefTop  = {prefTopHigh_q, prefTopMid, PREF_LOW_ONES}; // R15

  bwc_fwd_decode uDecode (
    .reqAddr      (reqAddr),
    .reqIsIo      (reqIsIo),
    .ioBottom     (ioBottom),
    .ioTop        (ioTop),
    .prefBottom   (prefBottom),
    .prefTop      (prefTop),
    .isaEn        (bridgeCtl_q[BC_ISA]),
    .vgaEn        (bridgeCtl_q[BC_VGA]),
    .vga16        (bridgeCtl_q[BC_VGA16]),
    .ioInWindow   (decIoWin),
    .prefInWindow (decPrefWin),
    .isaUpstream  (decIsa),
    .ioDownstream (decIoDown),
    .vgaHit       (decVga)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      decValid_q <= 1'b0;
      ioWin_q    <= 1'b0;
      prefWin_q  <= 1'b0;
      isaUp_q    <= 1'b0;
      ioDown_q   <= 1'b0;
      vga_q      <= 1'b0;
    end else begin
      decValid_q <= reqValid;
      ioWin_q    <= reqValid && decIoWin; // R04
      prefWin_q  <= reqValid && decPrefWin; // R04
      isaUp_q    <= reqValid && decIsa; // R09
      ioDown_q   <= reqValid && decIoDown; // R09
      vga_q      <= reqValid && decVga; // R10
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      poison_q <= 1'b0;
      errOut_q <= ERR_NONE;
    end else begin
      poison_q <= poisonIn && bridgeCtl_q[BC_POISON]; // R07
      errOut_q <= bridgeCtl_q[BC_ERRFWD] ? errMsgIn : ERR_NONE; // R08
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      portRst_q    <= 1'b0;
      allDownRst_q <= 1'b0;
    end else begin
      portRst_q    <= bridgeCtl_q[BC_SBR] && !portIsUpstream; // R13
      allDownRst_q <= bridgeCtl_q[BC_SBR] && portIsUpstream; // R13
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign decValid       = decValid_q;
  assign ioInWindow     = ioWin_q;
  assign prefInWindow   = prefWin_q;
  assign isaUpstream    = isaUp_q;
  assign ioDownstream   = ioDown_q;
  assign vgaHit         = vga_q;
  assign poisonDetected = poison_q;
  assign errMsgOut      = errOut_q;
  assign portRstOut     = portRst_q;
  assign allDownRstOut  = allDownRst_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence apbSetup(logic [ADDR_W-1:0] a, logic w);
    psel && !penable && paddr == a && pwrite == w;
  endsequence

  sequence apbAccess;
    psel && penable && pready;
  endsequence

  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB access phase not answered in one cycle");
  pref_top_wr_a: assert property (apbSetup(OFS_PREF_TOP_HI, 1'b1) ##1 apbAccess
      |=> prefTopHigh_q == $past(pwdata)) // R01
    else $error("Prefetch top high write lost");
  io_halves_wr_a: assert property (apbSetup(OFS_IO_HI, 1'b1) ##1 apbAccess
      |=> {ioTopHigh_q, ioBottomHigh_q} == $past(pwdata)) // R02
    else $error("I/O upper halves write lost");
  cap_ptr_rd_a: assert property (apbSetup(OFS_CAP_PTR, 1'b0)
      |=> prdata == {24'h00_0000, CAP_PTR_VAL}) // R05
    else $error("Capability pointer read wrong");
  legacy_zero_a: assert property ((bridgeCtl_q & ~BC_WR_MASK) == 16'h0000) // R14
    else $error("Legacy control bit not zero");
  poison_gate_a: assert property (poisonDetected |-> $past(bridgeCtl_q[BC_POISON])
      && $past(poisonIn)) // R07
    else $error("Poison reported while ignored");
  err_fwd_a: assert property (errMsgOut == ($past(bridgeCtl_q[BC_ERRFWD]) ?
      $past(errMsgIn) : ERR_NONE)) // R08
    else $error("Error message forwarding wrong");
  sbr_route_a: assert property (bridgeCtl_q[BC_SBR] && $stable(bridgeCtl_q) |=>
      (portRstOut || allDownRstOut) && !(portRstOut && allDownRstOut)) // R13
    else $error("Secondary bus reset not routed");
  vga_gate_a: assert property (vgaHit |-> $past(bridgeCtl_q[BC_VGA])) // R10
    else $error("VGA forward while disabled");
  isa_route_a: assert property (isaUpstream |-> !ioDownstream && ioInWindow) // R09
    else $error("ISA range sent downstream");

  // Unmapped offsets answer with an error in the access cycle
  slverr_unmapped_a: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("Unmapped access without slave error");
  ctl_write_a: assert property (apbSetup(OFS_INT_BRIDGE, 1'b1) ##1 apbAccess
      |=> bridgeCtl_q == ($past(pwdata[31:16]) & BC_WR_MASK)) // R14
    else $error("Bridge control write wrong");
  line_write_a: assert property (apbSetup(OFS_INT_BRIDGE, 1'b1) ##1 apbAccess
      |=> intLine_q == $past(pwdata[7:0]))
    else $error("Interrupt line write lost");

  // Pin byte only follows the serial load on a downstream port
  pin_load_a: assert property (intPinLoad && !portIsUpstream
      |=> intPin_q == $past(intPinValue)) // R06
    else $error("Interrupt pin load lost");
  pin_upstream_a: assert property (intPinLoad && portIsUpstream |=> $stable(intPin_q)) // R06
    else $error("Interrupt pin changed on upstream port");

  // Decision flags only follow a valid lookup
  pref_valid_a: assert property (prefInWindow || ioInWindow |-> decValid) // R04
    else $error("Window flag without lookup");
  isa_off_a: assert property (decValid && !$past(bridgeCtl_q[BC_ISA]) |-> !isaUpstream) // R09
    else $error("ISA routing while disabled");
  io_split_a: assert property (ioInWindow |-> isaUpstream != ioDownstream) // R09
    else $error("I/O window hit routed both ways or none");

  // Sixteen-bit decode rejects aliases above the first 1KB
  vga_alias_a: assert property (reqValid && reqIsIo && bridgeCtl_q[BC_VGA16] &&
      reqAddr[15:10] != IO_ALIAS_ZERO |=> !vgaHit) // R12
    else $error("VGA alias hit with 16-bit decode");
  rst_idle_a: assert property (!bridgeCtl_q[BC_SBR] |=> !portRstOut && !allDownRstOut) // R13
    else $error("Port reset without secondary bus reset");
endmodule

/* File: bwc_link_model.sv */
// Purpose: Far-side link model issuing lookups, poison and error messages
// Assumes: Driven from the bench through its drive task
// Notes:   Released address lines show the inverse of the last value
module bwc_link_model (
  input  wire logic        sys_clk,
  output logic             reqValid,
  output logic             reqIsIo,
  output logic      [63:0] reqAddr,
  output logic             poisonIn,
  output logic      [2:0]  errMsgIn
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reqValid = 1'b0;
    reqIsIo  = 1'b0;
    reqAddr  = '0;
    poisonIn = 1'b0;
    errMsgIn = 3'h0;
  end

  // One-cycle event, then release; outputs settle after the next edge
  task automatic drive(input logic v, input logic io, input logic [63:0] a,
                       input logic p, input logic [2:0] e);
    @(posedge sys_clk);
    reqValid <= v;
    reqIsIo  <= io;
    reqAddr  <= a;
    poisonIn <= p;
    errMsgIn <= e;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    reqIsIo  <= ~io;
    reqAddr  <= ~a;
    poisonIn <= 1'b0;
    errMsgIn <= 3'h0;
    #1;
  endtask
endmodule

/* File: bridge_window_control_regs_tb_top.sv */
// Purpose: Self-checking bench for the bridge window and control registers
// Assumes: APB slave answers after one access cycle
// Notes:   Lookup flags packed as io, pref, isa, iodown, vga
module bridge_window_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bwc_pkg::*;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, portIsUpstream = 0, intPinLoad = 0;
  logic [7:0] intPinValue = '0;
  logic [31:0] ioBottomLow = '0, ioTopLow = '0;
  logic [63:0] prefBottom = '0, reqAddr;
  logic [11:0] prefTopMid = '0;
  logic reqValid, reqIsIo, poisonIn, poisonDetected, portRstOut, allDownRstOut;
  logic [2:0] errMsgIn, errMsgOut;
  logic decValid, ioInWindow, prefInWindow, isaUpstream, ioDownstream, vgaHit;
  int errors = 0;
  int total_checks = 0;

  bwc_regs uut (.*);
  bwc_link_model lm (.*);

  always #5 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("[ERR] %0t bus timeout", $time);
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, '0);
    chk(rd, e);
    chk(32'(err), 32'(x));
  endtask

  task automatic look(input logic io, input logic [63:0] a, input logic [4:0] e);
    lm.drive(1'b1, io, a, 1'b0, 3'h0);
    chk(32'({decValid, ioInWindow, prefInWindow, isaUpstream, ioDownstream, vgaHit}),
        32'({1'b1, e}));
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(OFS_PREF_TOP_HI, 32'h0000_0000, 1'b0);
    rdc(OFS_IO_HI, 32'h0000_0000, 1'b0);
    rdc(OFS_CAP_PTR, 32'h0000_0040, 1'b0);
    rdc(OFS_INT_BRIDGE, 32'h0000_0000, 1'b0);
    apb(1'b1, OFS_PREF_TOP_HI, 32'hffff_ffff);
    rdc(OFS_PREF_TOP_HI, 32'hffff_ffff, 1'b0);
    apb(1'b1, OFS_IO_HI, 32'h1234_5678);
    rdc(OFS_IO_HI, 32'h1234_5678, 1'b0);
    apb(1'b1, OFS_CAP_PTR, 32'h0000_0000);
    rdc(OFS_CAP_PTR, 32'h0000_0040, 1'b0);
    apb(1'b1, OFS_INT_BRIDGE, 32'hffff_ffff);
    rdc(OFS_INT_BRIDGE, 32'h005f_00ff, 1'b0);
    chk(32'({portRstOut, allDownRstOut}), 32'h0000_0002);
    lm.drive(1'b0, 1'b0, '0, 1'b1, 3'h7);
    chk(32'({poisonDetected, errMsgOut}), 32'h0000_000f);
    portIsUpstream <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'({portRstOut, allDownRstOut}), 32'h0000_0001);
    portIsUpstream <= 1'b0;
    rdc(8'h40, 32'h0000_0000, 1'b1);
    apb(1'b1, OFS_INT_BRIDGE, 32'h0000_0000);
    rdc(OFS_INT_BRIDGE, 32'h0000_0000, 1'b0);
    lm.drive(1'b0, 1'b0, '0, 1'b1, 3'h7);
    chk(32'({poisonDetected, errMsgOut}), 32'h0000_0000);
    chk(32'({portRstOut, allDownRstOut}), 32'h0000_0000);
    @(posedge sys_clk);
    intPinLoad <= 1'b1;
    intPinValue <= 8'h01;
    @(posedge sys_clk);
    intPinLoad <= 1'b0;
    rdc(OFS_INT_BRIDGE, 32'h0000_0100, 1'b0);
    apb(1'b1, OFS_IO_HI, 32'h0001_0001);
    apb(1'b1, OFS_PREF_TOP_HI, 32'h0000_0000);
    ioBottomLow <= 32'h0000_1000;
    ioTopLow <= 32'h0000_2000;
    prefTopMid <= 12'h001;
    look(1'b1, 64'h0001_1000, 5'b10010);
    look(1'b1, 64'h0001_2000, 5'b10010);
    look(1'b1, 64'h0001_2001, 5'b00000);
    look(1'b1, 64'h0001_0fff, 5'b00000);
    look(1'b0, 64'h001f_ffff, 5'b01000);
    look(1'b0, 64'h0020_0000, 5'b00000);
    apb(1'b1, OFS_IO_HI, 32'h0000_0000);
    apb(1'b1, OFS_INT_BRIDGE, 32'h0004_0000);
    ioBottomLow <= 32'h0000_0000;
    ioTopLow <= 32'h0000_ffff;
    look(1'b1, 64'h0000_0100, 5'b10100);
    look(1'b1, 64'h0000_00ff, 5'b10010);
    apb(1'b1, OFS_INT_BRIDGE, 32'h0008_0000);
    ioBottomLow <= 32'h0000_ffff;
    ioTopLow <= 32'h0000_0000;
    prefBottom <= 64'hffff_0000_0000;
    look(1'b0, 64'h000a_0000, 5'b00001);
    look(1'b0, 64'h000b_ffff, 5'b00001);
    look(1'b0, 64'h000c_0000, 5'b00000);
    look(1'b1, 64'h0000_03b0, 5'b00001);
    look(1'b1, 64'h0000_03bc, 5'b00000);
    look(1'b1, 64'h0000_03df, 5'b00001);
    look(1'b1, 64'h0000_03e0, 5'b00000);
    look(1'b1, 64'h0000_07b0, 5'b00001);
    apb(1'b1, OFS_INT_BRIDGE, 32'h0018_0000);
    look(1'b1, 64'h0000_07b0, 5'b00000);
    look(1'b1, 64'h0000_03c0, 5'b00001);
    apb(1'b1, OFS_INT_BRIDGE, 32'h0000_0000);
    look(1'b0, 64'h000a_0000, 5'b00000);
    final_report();
  end
endmodule
